// ### logic/tlps_scheduler.sv
// Scan scheduler with calibration step and low-power sleep insertion.
//
// Summary of operation
// R1: Calibration update after every completed conversion.
// R2: Power config bit 1 enables low power.
// R3: Low power alternates scan cycles and sleeps.
// R4: Each cycle converts every enabled sensor once.
// R5: Sleep lasts sleep config value in milliseconds.
// R6: Touch in low power stops sleep insertion.
// R7: Sleep wait register sets touch-free hold time.
// R8: Without low power, cycles run back-to-back.
// R9: Each new touch restarts the hold timer.
`timescale 1ns/1ps

module tlps_scheduler #(
  parameter int MS_CYCLES = tlps_pkg::MS_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire tlps_pkg::tlps_reg_req_t reg_req,
  output tlps_pkg::tlps_conv_req_t     conv_req,
  output logic [15:0]                  reg_rdata,
  input  wire logic [19:0]             sensor_en,
  input  wire logic                    conv_done,
  input  wire logic                    touch_det,
  output logic                         calib_update,
  output logic                         sleeping,
  output logic                         touch_hold
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]         power_configuration;
  logic [15:0]         sleep_wait_time;
  logic [15:0]         sleep_interval_config;
  tlps_pkg::tlps_state_t state;
  tlps_pkg::tlps_state_t next_state;
  logic [4:0]          idx;
  logic [15:0]         sleep_cnt;
  logic [15:0]         hold_cnt;
  logic                ms_tick;
  logic                lp_en;
  logic                touch_evt;
  logic                enter_sleep;

  assign lp_en       = power_configuration[tlps_pkg::LP_EN_BIT];
  assign touch_evt   = (state == tlps_pkg::ST_WAIT) && conv_done && touch_det && lp_en;
  assign enter_sleep = (state != tlps_pkg::ST_SLEEP) && (next_state == tlps_pkg::ST_SLEEP);

  // Register writes from the serial interface.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_configuration   <= tlps_pkg::POWER_CFG_RESET;
      sleep_wait_time       <= tlps_pkg::SLEEP_WAIT_RESET;
      sleep_interval_config <= tlps_pkg::SLEEP_CFG_RESET;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        // R2: low power enable
        tlps_pkg::ADDR_POWER_CFG:  power_configuration   <= reg_req.wdata;
        tlps_pkg::ADDR_SLEEP_WAIT: sleep_wait_time       <= reg_req.wdata;
        tlps_pkg::ADDR_SLEEP_CFG:  sleep_interval_config <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses read as zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        tlps_pkg::ADDR_POWER_CFG:  reg_rdata <= power_configuration;
        tlps_pkg::ADDR_SLEEP_WAIT: reg_rdata <= sleep_wait_time;
        tlps_pkg::ADDR_SLEEP_CFG:  reg_rdata <= sleep_interval_config;
        default:                   reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  tlps_ms_tick #(
    .WIDTH  (tlps_pkg::TICK_W),
    .PERIOD (MS_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (enter_sleep),
    .tick    (ms_tick)
  );

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  // Next-state choice for the scan, calibration and sleep sequence.
  always_comb begin
    next_state = state;
    case (state)
      tlps_pkg::ST_START: begin
        if (sensor_en[idx]) begin
          next_state = tlps_pkg::ST_WAIT;
        end else if (idx == tlps_pkg::LAST_SENSOR) begin
          next_state = tlps_pkg::ST_END;
        end
      end
      tlps_pkg::ST_WAIT: begin
        if (conv_done) begin
          next_state = tlps_pkg::ST_CALIB;
        end
      end
      tlps_pkg::ST_CALIB: begin
        next_state = (idx == tlps_pkg::LAST_SENSOR) ? tlps_pkg::ST_END : tlps_pkg::ST_START;
      end
      tlps_pkg::ST_END: begin
        // R3: sleep between cycles
        // R6: no sleep while held
        // R8: back-to-back when disabled
        if (lp_en && hold_cnt == 16'h0000 && sleep_interval_config != 16'h0000) begin
          next_state = tlps_pkg::ST_SLEEP;
        end else begin
          next_state = tlps_pkg::ST_START;
        end
      end
      tlps_pkg::ST_SLEEP: begin
        // R5: sleep length in ms
        if (!lp_en || (ms_tick && sleep_cnt == 16'h0001)) begin
          next_state = tlps_pkg::ST_START;
        end
      end
      default: next_state = tlps_pkg::ST_START;
    endcase
  end

  // State register and sleep status output.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state    <= tlps_pkg::ST_START;
      sleeping <= 1'b0;
    end else begin
      state    <= next_state;
      sleeping <= (next_state == tlps_pkg::ST_SLEEP);
    end
  end

  // R4: visit each enabled sensor
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx      <= 5'h00;
      conv_req <= '0;
    end else begin
      conv_req.start <= (state == tlps_pkg::ST_START) && sensor_en[idx];
      conv_req.sensor <= idx;
      if (state == tlps_pkg::ST_END) begin
        idx <= 5'h00;
      end else if ((state == tlps_pkg::ST_START && !sensor_en[idx] &&
                    idx != tlps_pkg::LAST_SENSOR) ||
                   (state == tlps_pkg::ST_CALIB && idx != tlps_pkg::LAST_SENSOR)) begin
        idx <= idx + 5'h01;
      end
    end
  end

  // R1: calibrate after each conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      calib_update <= 1'b0;
    end else begin
      calib_update <= (state == tlps_pkg::ST_WAIT) && conv_done;
    end
  end

  // Sleep interval counter, loaded on entry and counted down on ticks.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleep_cnt <= 16'h0000;
    end else if (enter_sleep) begin
      sleep_cnt <= sleep_interval_config;
    end else if (state == tlps_pkg::ST_SLEEP && ms_tick && sleep_cnt != 16'h0000) begin
      sleep_cnt <= sleep_cnt - 16'h0001;
    end
  end

  // R7: hold time from wait register
  // R9: touch reload wins over countdown
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt   <= 16'h0000;
      touch_hold <= 1'b0;
    end else begin
      if (touch_evt) begin
        hold_cnt   <= sleep_wait_time;
        touch_hold <= (sleep_wait_time != 16'h0000);
      end else if (ms_tick && hold_cnt != 16'h0000) begin
        hold_cnt   <= hold_cnt - 16'h0001;
        touch_hold <= (hold_cnt != 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_conv_finish;
    (state == tlps_pkg::ST_WAIT) && conv_done;
  endsequence

  sequence s_cycle_end;
    state == tlps_pkg::ST_END;
  endsequence

  a_calib_after_conv: assert property ( // R1
    s_conv_finish |=> calib_update ##1 !calib_update)
    else $error("calibration pulse missing after conversion");

  a_lp_enable_write: assert property ( // R2
    reg_req.wr && reg_req.addr == tlps_pkg::ADDR_POWER_CFG |=>
      lp_en == $past(reg_req.wdata[tlps_pkg::LP_EN_BIT]))
    else $error("low power enable does not follow write");

  a_no_scan_asleep: assert property ( // R3
    sleeping |-> !conv_req.start && state == tlps_pkg::ST_SLEEP)
    else $error("conversion started while sleeping");

  a_enabled_sensor_only: assert property ( // R4
    conv_req.start |-> sensor_en[conv_req.sensor] && state == tlps_pkg::ST_WAIT)
    else $error("conversion requested for disabled sensor");

  a_sleep_load_value: assert property ( // R5
    enter_sleep |=> sleep_cnt == $past(sleep_interval_config))
    else $error("sleep counter not loaded from configuration");

  a_hold_blocks_sleep: assert property ( // R6
    s_cycle_end and (hold_cnt != 16'h0000) |=> state == tlps_pkg::ST_START)
    else $error("sleep inserted during touch hold");

  a_hold_countdown: assert property ( // R7
    ms_tick && !touch_evt && hold_cnt != 16'h0000 |=> hold_cnt == $past(hold_cnt) - 16'h0001)
    else $error("hold timer did not count down");

  a_back_to_back: assert property ( // R8
    s_cycle_end and !lp_en |=> state == tlps_pkg::ST_START)
    else $error("delay inserted with low power off");

  a_touch_restart: assert property ( // R9
    touch_evt |=> hold_cnt == $past(sleep_wait_time))
    else $error("touch did not restart hold timer");

endmodule // tlps_scheduler

// ### logic/tlps_pkg.sv
// Shared constants and types of the touch low-power scheduler.
package tlps_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_POWER_CFG   = 8'h02;
  localparam logic [7:0]  ADDR_SLEEP_WAIT  = 8'h03;
  localparam logic [7:0]  ADDR_SLEEP_CFG   = 8'h56;
  localparam int          LP_EN_BIT        = 1;
  localparam logic [15:0] POWER_CFG_RESET  = 16'h0000;
  localparam logic [15:0] SLEEP_WAIT_RESET = 16'h0000;
  localparam logic [15:0] SLEEP_CFG_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Sensors and timing
  // ----------------------------------------------------------------
  localparam int          NUM_SENSORS = 20;
  localparam logic [4:0]  LAST_SENSOR = 5'h13;
  localparam int          CLK_PERIOD_PS = 10000;
  localparam int          MS_TIME_PS    = 1000000000;
  localparam int          MS_CYCLES     = MS_TIME_PS / CLK_PERIOD_PS;
  localparam int          TICK_W        = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_START,
    ST_WAIT,
    ST_CALIB,
    ST_END,
    ST_SLEEP
  } tlps_state_t;

  // Conversion request toward the sensing converter.
  typedef struct packed {
    logic       start;
    logic [4:0] sensor;
  } tlps_conv_req_t;

  // Register access from the serial interface.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tlps_reg_req_t;

endpackage

// ### logic/tlps_ms_tick.sv
// Millisecond time base with restart.
`timescale 1ns/1ps

module tlps_ms_tick #(
  parameter int WIDTH  = tlps_pkg::TICK_W,
  parameter int PERIOD = tlps_pkg::MS_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);

  localparam logic [WIDTH-1:0] TOP = WIDTH'(PERIOD - 1);

  logic [WIDTH-1:0] count;

  // Counts clock cycles and pulses once per period; clr restarts the period.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clr) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (count == TOP);
      count <= (count == TOP) ? '0 : count + WIDTH'(1);
    end
  end

endmodule // tlps_ms_tick

// ### verif/tlps_conv_model.sv
// Behavioural model of the sensing converter beside the scheduler.
`timescale 1ns/1ps

module tlps_conv_model #(
  parameter int DELAY = 4
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire tlps_pkg::tlps_conv_req_t conv_req,
  input  wire logic                     touch,
  output logic                          conv_done,
  output logic                          touch_det
);
  int cnt;

  // Done follows each start after DELAY cycles; the touch line toggles
  // outside that cycle so a stale value is never mistaken for a result.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      conv_done <= 1'b0;
      touch_det <= 1'b0;
    end else begin
      conv_done <= (cnt == 1);
      touch_det <= (cnt == 1) ? touch : ~touch_det;
      if (conv_req.start) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // tlps_conv_model

// ### verif/touch_low_power_scheduler_tb.sv
// Self-checking bench of the touch low-power scheduler.
`timescale 1ns/1ps

module touch_low_power_scheduler_tb;
  logic                     clk_sys = 1'b0;
  logic                     rst = 1'b1;
  tlps_pkg::tlps_reg_req_t  reg_req = '0;
  tlps_pkg::tlps_conv_req_t conv_req;
  logic [15:0]              reg_rdata;
  logic [19:0]              sensor_en = 20'h00005;
  logic                     conv_done, touch_det, calib_update, sleeping, touch_hold;
  logic                     touch = 1'b0;
  logic                     done_seen = 1'b0;
  logic [15:0]              rd;
  logic [15:0]              starts = 16'h0000;
  int                       errors = 0;
  int                       samples_checked = 0;
  int                       n;
  logic [7:0]               row_addr [4] = '{8'h02, 8'h03, 8'h56, 8'h10};
  logic [15:0]              row_data [4] = '{16'ha5a4, 16'h1234, 16'hfedc, 16'hffff};
  logic [15:0]              row_exp  [4] = '{16'ha5a4, 16'h1234, 16'hfedc, 16'h0000};

  tlps_scheduler #(.MS_CYCLES(20)) tlps_scheduler_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .conv_req(conv_req),
    .reg_rdata(reg_rdata), .sensor_en(sensor_en), .conv_done(conv_done),
    .touch_det(touch_det), .calib_update(calib_update), .sleeping(sleeping),
    .touch_hold(touch_hold));

  tlps_conv_model tlps_conv_model_inst (
    .clk_sys(clk_sys), .rst(rst), .conv_req(conv_req), .touch(touch),
    .conv_done(conv_done), .touch_det(touch_det));

  // Clock of 10 ns period.
  always #5 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watches every cycle: calibration after each done, no scan while asleep.
  always @(negedge clk_sys) begin
    if (!rst) begin
      if (done_seen) check(calib_update, 1'b1);
      // Counts conversion starts and checks that each one names an enabled sensor.
      if (conv_req.start) begin
        starts = starts + 16'h0001;
        check(sensor_en[conv_req.sensor], 1'b1);
      end
      if (sleeping) check(conv_req.start, 1'b0);
      if (touch_hold) check(sleeping, 1'b0);
    end
    done_seen = conv_done;
  end

  // Cuts a hang short.
  initial begin
    #100000;
    errors++;
    give_verdict();
  end

  // Main sequence of tests.
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      reg_wr(row_addr[i], row_data[i]);
      reg_rd(row_addr[i], rd);
      check(rd, row_exp[i]);
    end
    $display("test registers done");
    reg_wr(8'h56, 16'h0003);
    reg_wr(8'h02, 16'hfffd);
    repeat (300) @(negedge clk_sys) check(sleeping, 1'b0);
    $display("test full power done");
    reg_wr(8'h02, 16'h0002);
    reg_wr(8'h03, 16'h0003);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      starts = 16'h0000;
      while (!sleeping && n < 2000) begin @(negedge clk_sys); n++; end
      check(n < 2000, 1'b1);
      // one start per enabled sensor between two sleeps.
      if (k == 1) check(starts, 16'h0002);
      n = 0;
      while (sleeping && n < 2000) begin @(negedge clk_sys); n++; end
      check(n == 60 || n == 61, 1'b1);
    end
    $display("test sleep done");
    // repeated touches keep the hold alive
    touch = 1'b1;
    n = 0;
    while (!touch_hold && n < 2000) begin @(negedge clk_sys); n++; end
    check(n < 2000, 1'b1);
    repeat (150) @(negedge clk_sys) check(touch_hold, 1'b1);
    // Releases the touch just after a touched conversion, so the hold starts there.
    while (!calib_update) @(negedge clk_sys);
    touch = 1'b0;
    n = 0;
    while (touch_hold && n < 200) begin @(negedge clk_sys); n++; end
    check(n >= 41 && n <= 60, 1'b1);
    n = 0;
    while (!sleeping && n < 200) begin @(negedge clk_sys); n++; end
    check(n < 200, 1'b1);
    reg_wr(8'h02, 16'h0000);
    @(negedge clk_sys);
    check(sleeping, 1'b0);
    $display("test touch hold done");
    // Reset in mid-run clears the power configuration register and the status outputs.
    reg_wr(8'h02, 16'h0002);
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check(sleeping, 1'b0);
    check(touch_hold, 1'b0);
    reg_rd(8'h02, rd);
    check(rd, tlps_pkg::POWER_CFG_RESET);
    $display("test reset done");
    give_verdict();
  end
endmodule // touch_low_power_scheduler_tb
